// [hw/ftm_pkg.sv]
// constants and types of the fault-tolerant bus failure manager
package ftm_pkg;
  // clock and counter widths
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned CNT_W  = 12;
  localparam int unsigned TO_W   = 24;
  localparam int unsigned FAIL_N = 8;

  // failure type bit positions within the failure vector
  localparam int unsigned F1  = 0;
  localparam int unsigned F2  = 1;
  localparam int unsigned F3  = 2;
  localparam int unsigned F4  = 3;
  localparam int unsigned F5  = 4;
  localparam int unsigned F6  = 5;
  localparam int unsigned F6A = 6;
  localparam int unsigned F7  = 7;

  // failure groupings
  localparam logic [7:0] SW_MASK    = 8'hB4; // 3,5,6,7 force single-wire
  localparam logic [7:0] LP_MASK    = 8'h8C; // 3,4,7 still watched in low power
  localparam logic [7:0] TERM_H_OFF = 8'h14; // 3,5 kill high-side termination
  localparam logic [7:0] TERM_L_OFF = 8'hE0; // 6,6a,7 kill low-side termination
  localparam logic [7:0] DRV_H_OFF  = 8'h14; // 3,5 kill high-side driver
  localparam logic [7:0] DRV_L_OFF  = 8'hA0; // 6,7 kill low-side driver

  // timing: figures in ns, cycle counts derived
  localparam int unsigned SW_ENTRY_NS   = 30000;
  localparam int unsigned SW_EXIT_NS    = 30000;
  localparam int unsigned GOSLEEP_NS    = 50000;
  localparam int unsigned WAKE_BIT_NS   = 8000;
  localparam int unsigned WAKE_DOM_BITS = 5;
  localparam int unsigned TXD_TO_NS     = 2000000;
  localparam int unsigned SW_ENTRY_CYC  = (SW_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SW_EXIT_CYC   = (SW_EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GOSLEEP_CYC   = GOSLEEP_NS / CLK_NS;
  localparam int unsigned WAKE_DOM_CYC  =
    (WAKE_DOM_BITS * WAKE_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TXD_TO_CYC    = (TXD_TO_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] SW_ENTRY_CNT  = CNT_W'(SW_ENTRY_CYC);
  localparam logic [CNT_W-1:0] SW_EXIT_CNT   = CNT_W'(SW_EXIT_CYC);
  localparam logic [CNT_W-1:0] GOSLEEP_LAST  = CNT_W'(GOSLEEP_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_DOM_LAST = CNT_W'(WAKE_DOM_CYC - 1);

  // reset values
  localparam logic POR_FLAG_RST = 1'b1;

  typedef struct packed {
    logic val;
    logic drv;
  } ftm_pin_t;

  typedef struct packed {
    logic canh_drv;
    logic canl_drv;
    logic rth_on;
    logic rtl_on;
  } ftm_bus_ctl_t;

  typedef enum logic [4:0] {
    ST_NORMAL   = 5'h01,
    ST_PWR_STBY = 5'h02,
    ST_STBY     = 5'h04,
    ST_GOSLEEP  = 5'h08,
    ST_SLEEP    = 5'h10
  } ftm_state_t;
endpackage

// [hw/ftm_persist.sv]
// persistence filter: output follows input only after it held long enough
`timescale 1ns/1ps
module ftm_persist #(
  parameter logic [ftm_pkg::CNT_W-1:0] SET_CNT = ftm_pkg::SW_ENTRY_CNT,
  parameter logic [ftm_pkg::CNT_W-1:0] CLR_CNT = ftm_pkg::SW_EXIT_CNT
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      filt
);
  logic [ftm_pkg::CNT_W-1:0] cnt_reg;
  logic                      filt_reg;
  wire                       differ;
  wire [ftm_pkg::CNT_W-1:0]  limit;
  wire                       done;

  // a glitch shorter than the limit resets the count, so rf bursts never switch
  assign differ = raw ^ filt_reg;
  assign limit  = filt_reg ? CLR_CNT : SET_CNT;
  assign done   = differ && (cnt_reg >= limit - 1'b1);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg <= (differ && !done) ? cnt_reg + 1'b1 : '0;
      if (done) begin
        filt_reg <= raw;
      end
    end
  end

  assign filt = filt_reg;
endmodule

// [hw/ftm_dom_timer.sv]
// transmit dominant timeout: trips when the input stays dominant too long
`timescale 1ns/1ps
module ftm_dom_timer #(
  parameter int unsigned LIMIT = ftm_pkg::TXD_TO_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic dom,
  output logic      timeout
);
  localparam logic [ftm_pkg::TO_W-1:0] LAST = ftm_pkg::TO_W'(LIMIT - 1);

  logic [ftm_pkg::TO_W-1:0] cnt_reg;
  logic                     to_reg;
  wire                      hit;

  assign hit = dom && !to_reg && (cnt_reg == LAST);

  // once tripped, only a recessive input releases the lock
  always_ff @(posedge clk) begin
    if (rst || !dom) begin
      cnt_reg <= '0;
      to_reg  <= 1'b0;
    end else if (hit) begin
      to_reg <= 1'b1;
    end else if (!to_reg) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign timeout = to_reg;
endmodule

// [hw/ftm_bus_fail_mgr.sv]
// digital control of a fault-tolerant low-speed can transceiver
//
// What this block does
// - failure detection runs fully in normal mode on both wires.
// - a detected failure reconfigures transmitter and receiver for its type.
// - automatic differential or single-wire choice; back to normal when fault clears.
// - failures 1, 2, 4, 6a keep differential receive and full transmitter.
// - single-wire mode entered only after the failure persists a delay.
// - differential mode restored after the failure is absent a delay.
// - failures 3, 5, 6, 7 switch off that wire's termination and driver; 6a only the low termination.
// - bus wake accepted from dominant on either wire alone.
// - any wiring failure drives the fault flag low.
// - fault flag returns high after the failure is gone.
// - thermal shutdown also drives the fault flag low.
// - transmit timer stops a permanently dominant bus.
// - undriven transmit input reads recessive.
// - fault flag shows error, wake or power-on flag by mode.
// - undriven standby control reads low, selecting standby, or go-to-sleep with enable high.
// - undriven mode input reads low.
// - both edges on the local wake input are wake events.
// - dominant is transmit low, high wire up, low wire down.
// - remote wake needs five consecutive dominant bit times.
// - power-on flag read in power-on standby, cleared entering normal.
// - in low power, receive shows pending wake; fault does too, except in power-on standby.
// - wake during go-to-sleep wins; inhibit stays active.
`timescale 1ns/1ps
module ftm_bus_fail_mgr #(
  parameter int unsigned TXD_TO_CYC = ftm_pkg::TXD_TO_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire ftm_pkg::ftm_pin_t             txd_pin,
  input  wire ftm_pkg::ftm_pin_t             standby_ctl_n,
  input  wire ftm_pkg::ftm_pin_t             mode_en_pin,
  input  wire logic                          local_wake_in,
  input  wire logic                          canh_dom_in,
  input  wire logic                          canl_dom_in,
  input  wire logic                          diff_dom_in,
  input  wire logic [ftm_pkg::FAIL_N-1:0]    fail_raw_in,
  input  wire logic                          thermal_sd_in,
  input  wire logic                          vbat_por_in,
  output logic                               rxd_out,
  output logic                               fault_flag_out_n,
  output logic                               regulator_inhibit_out,
  output ftm_pkg::ftm_bus_ctl_t              bus_ctl_out,
  output logic                               single_wire_out,
  output logic                               tx_timeout_out
);
  ftm_pkg::ftm_state_t       state_reg;
  ftm_pkg::ftm_state_t       state_next;
  ftm_pkg::ftm_state_t       pin_state;
  ftm_pkg::ftm_bus_ctl_t     bus_ctl_reg;
  ftm_pkg::ftm_bus_ctl_t     bus_ctl_next;
  logic [ftm_pkg::CNT_W-1:0] gs_cnt_reg;
  logic [ftm_pkg::CNT_W-1:0] dom_cnt_reg;
  logic [ftm_pkg::FAIL_N-1:0] fail_filt;
  logic                      wake_prev_reg;
  logic                      wake_pend_reg;
  logic                      por_reg;
  logic                      rxd_reg;
  logic                      fault_reg;
  logic                      inh_reg;
  logic                      sw_reg;
  logic                      tx_to;

  // pin defaults for undriven inputs
  wire txd_rec = txd_pin.drv ? txd_pin.val : 1'b1;
  wire stb_hi  = standby_ctl_n.drv ? standby_ctl_n.val : 1'b0;
  wire en_hi   = mode_en_pin.drv ? mode_en_pin.val : 1'b0;

  // mode request from the two control inputs
  wire req_gosleep = !stb_hi && en_hi;
  assign pin_state = (stb_hi && en_hi)  ? ftm_pkg::ST_NORMAL :
                     (stb_hi && !en_hi) ? ftm_pkg::ST_PWR_STBY :
                     req_gosleep        ? ftm_pkg::ST_GOSLEEP :
                                          ftm_pkg::ST_STBY;

  wire is_normal    = (state_reg == ftm_pkg::ST_NORMAL);
  wire low_power    = !is_normal;
  wire next_normal  = (state_next == ftm_pkg::ST_NORMAL);
  wire enter_normal = next_normal && !is_normal;
  wire gs_done      = (gs_cnt_reg == ftm_pkg::GOSLEEP_LAST);

  // failure detector: full in normal mode, only power-relevant types otherwise
  wire [ftm_pkg::FAIL_N-1:0] det_raw =
    fail_raw_in & (is_normal ? {ftm_pkg::FAIL_N{1'b1}} : ftm_pkg::LP_MASK);

  // each failure type debounced on its own so several can coexist
  genvar gi;
  generate
    for (gi = 0; gi < ftm_pkg::FAIL_N; gi++) begin : g_fail
      ftm_persist #(
        .SET_CNT (ftm_pkg::SW_ENTRY_CNT),
        .CLR_CNT (ftm_pkg::SW_EXIT_CNT)
      ) u_persist (
        .clk  (clk),
        .rst  (rst),
        .raw  (det_raw[gi]),
        .filt (fail_filt[gi])
      );
    end
  endgenerate

  // transmit dominant timeout
  ftm_dom_timer #(
    .LIMIT (TXD_TO_CYC)
  ) u_dom_timer (
    .clk     (clk),
    .rst     (rst),
    .dom     (!txd_rec),
    .timeout (tx_to)
  );

  // failure classification; types 1,2,4,6a leave the transmitter alone
  wire fail_any = |fail_filt;
  wire sw_mode  = |(fail_filt & ftm_pkg::SW_MASK);
  wire term_h   = |(fail_filt & ftm_pkg::TERM_H_OFF);
  wire term_l   = |(fail_filt & ftm_pkg::TERM_L_OFF);
  wire drv_h    = |(fail_filt & ftm_pkg::DRV_H_OFF);
  wire drv_l    = |(fail_filt & ftm_pkg::DRV_L_OFF);

  // transmitter: dominant is a low transmit level
  wire tx_dom = !txd_rec && !tx_to && !thermal_sd_in && next_normal;
  always_comb begin
    bus_ctl_next.canh_drv = tx_dom && !drv_h;
    bus_ctl_next.canl_drv = tx_dom && !drv_l;
    bus_ctl_next.rth_on   = !term_h;
    bus_ctl_next.rtl_on   = !term_l;
  end

  // receiver: single-wire reception uses the healthy wire's comparator
  wire rx_dom = drv_h ? canl_dom_in :
                drv_l ? canh_dom_in :
                diff_dom_in;

  // wake sources
  wire bus_dom_any = canh_dom_in || canl_dom_in;
  wire remote_wake = bus_dom_any && (dom_cnt_reg == ftm_pkg::WAKE_DOM_LAST);
  wire wake_edge   = local_wake_in ^ wake_prev_reg;
  wire wake_evt    = low_power && (wake_edge || remote_wake);

  // sticky flags: a new event wins over the clear on entering normal
  wire wake_pend_next = wake_evt || (wake_pend_reg && !enter_normal);
  wire por_next       = vbat_por_in || (por_reg && !enter_normal);

  // mode sequencing; wake in go-to-sleep blocks the sleep step
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ftm_pkg::ST_SLEEP: begin
        if (wake_pend_reg || vbat_por_in) begin
          state_next = ftm_pkg::ST_STBY;
        end else if (!req_gosleep) begin
          state_next = pin_state;
        end
      end
      ftm_pkg::ST_GOSLEEP: begin
        if (!req_gosleep) begin
          state_next = pin_state;
        end else if (gs_done && !wake_pend_reg && !wake_evt) begin
          state_next = ftm_pkg::ST_SLEEP;
        end
      end
      ftm_pkg::ST_NORMAL,
      ftm_pkg::ST_PWR_STBY,
      ftm_pkg::ST_STBY: begin
        state_next = pin_state;
      end
      default: begin
        state_next = ftm_pkg::ST_STBY;
      end
    endcase
  end

  // shared flag pin and receive pin, chosen by the coming mode
  wire fault_next =
    next_normal                             ? !(fail_any || thermal_sd_in) :
    (state_next == ftm_pkg::ST_PWR_STBY)    ? !por_next :
                                              !wake_pend_next;
  wire rxd_next = next_normal ? !rx_dom : !wake_pend_next;

  // mode state and counters
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= ftm_pkg::ST_STBY;
      gs_cnt_reg  <= '0;
      dom_cnt_reg <= '0;
    end else begin
      state_reg   <= state_next;
      gs_cnt_reg  <= (state_reg == ftm_pkg::ST_GOSLEEP && !gs_done) ? gs_cnt_reg + 1'b1 :
                     (state_reg == ftm_pkg::ST_GOSLEEP) ? gs_cnt_reg : '0;
      dom_cnt_reg <= !bus_dom_any ? '0 :
                     remote_wake ? dom_cnt_reg : dom_cnt_reg + 1'b1;
    end
  end

  // flags; the previous wake level starts at the pin's reset-time value
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_pend_reg <= 1'b0;
      por_reg       <= ftm_pkg::POR_FLAG_RST;
    end else begin
      wake_pend_reg <= wake_pend_next;
      por_reg       <= por_next;
    end
  end

  // wake edge history is a plain sample, so no edge is seen out of reset
  always_ff @(posedge clk) begin
    wake_prev_reg <= local_wake_in;
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_ctl_reg <= '{canh_drv: 1'b0, canl_drv: 1'b0, rth_on: 1'b1, rtl_on: 1'b1};
      rxd_reg     <= 1'b1;
      fault_reg   <= 1'b1;
      inh_reg     <= 1'b1;
      sw_reg      <= 1'b0;
    end else begin
      bus_ctl_reg <= bus_ctl_next;
      rxd_reg     <= rxd_next;
      fault_reg   <= fault_next;
      inh_reg     <= (state_next != ftm_pkg::ST_SLEEP);
      sw_reg      <= sw_mode;
    end
  end

  assign bus_ctl_out           = bus_ctl_reg;
  assign rxd_out               = rxd_reg;
  assign fault_flag_out_n      = fault_reg;
  assign regulator_inhibit_out = inh_reg;
  assign single_wire_out       = sw_reg;
  assign tx_timeout_out        = tx_to;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_gs_wake;
    (state_reg == ftm_pkg::ST_GOSLEEP) && wake_pend_reg && req_gosleep;
  endsequence

  // helper: cycles the type-3 input has disagreed with its filtered bit; a flip
  // restarts at one so a raw change on the flip edge is still counted
  logic [ftm_pkg::CNT_W-1:0] f3_run_reg;
  wire                       f3_same = (det_raw[ftm_pkg::F3] == fail_filt[ftm_pkg::F3]);
  always_ff @(posedge clk) begin
    if (rst || f3_same) begin
      f3_run_reg <= '0;
    end else if ($changed(fail_filt[ftm_pkg::F3])) begin
      f3_run_reg <= {{(ftm_pkg::CNT_W-1){1'b0}}, 1'b1};
    end else begin
      f3_run_reg <= f3_run_reg + 1'b1;
    end
  end

  chk_fail_flag_low: assert property (
    (next_normal && fail_any) |=> !fault_flag_out_n)
    else $error("fault flag not low with failure present");
  chk_fail_flag_high: assert property (
    (next_normal && !fail_any && !thermal_sd_in) |=> fault_flag_out_n)
    else $error("fault flag not released after recovery");
  chk_thermal_flag: assert property (
    (next_normal && thermal_sd_in) |=> !fault_flag_out_n && !bus_ctl_out.canh_drv)
    else $error("thermal shutdown not flagged or driver on");
  chk_timeout_recessive: assert property (
    tx_timeout_out |=> !bus_ctl_out.canh_drv && !bus_ctl_out.canl_drv)
    else $error("bus driven after transmit timeout");
  chk_sw_entry_delay: assert property (
    $rose(fail_filt[ftm_pkg::F3]) |-> (f3_run_reg == ftm_pkg::SW_ENTRY_CNT))
    else $error("single-wire entry without persistent failure");
  chk_sw_exit_delay: assert property (
    $fell(fail_filt[ftm_pkg::F3]) |-> (f3_run_reg == ftm_pkg::SW_EXIT_CNT))
    else $error("return to differential without persistent recovery");
  chk_wire_off: assert property (
    fail_filt[ftm_pkg::F3] |=> !bus_ctl_out.canh_drv && !bus_ctl_out.rth_on)
    else $error("defective high wire still active");
  chk_txd_pullup: assert property (
    !txd_pin.drv |=> !bus_ctl_out.canh_drv && !bus_ctl_out.canl_drv)
    else $error("undriven transmit input drove bus");
  chk_local_wake: assert property (
    (low_power && wake_edge && state_next == ftm_pkg::ST_STBY)
      |=> !fault_flag_out_n && !rxd_out)
    else $error("local wake edge not signalled");
  chk_gosleep_wake: assert property (
    s_gs_wake |=> (state_reg != ftm_pkg::ST_SLEEP) && regulator_inhibit_out)
    else $error("sleep entered despite pending wake");
  chk_por_clear: assert property (
    (enter_normal && !vbat_por_in) |=> !por_reg &&
      (fault_flag_out_n == !($past(fail_any) || $past(thermal_sd_in))))
    else $error("power-on flag not cleared on entering normal");
  chk_remote_wake: assert property (
    (remote_wake && low_power && state_next == ftm_pkg::ST_STBY) |=> !rxd_out)
    else $error("remote wake not signalled");
  chk_full_tx: assert property (
    (tx_dom && !(|(fail_filt & ftm_pkg::SW_MASK)))
      |=> bus_ctl_out.canh_drv && bus_ctl_out.canl_drv)
    else $error("transmitter not fully active under a differential failure");
  chk_inhibit_sleep: assert property (
    regulator_inhibit_out == (state_reg != ftm_pkg::ST_SLEEP))
    else $error("inhibit output disagrees with sleep state");
  chk_undriven_stby: assert property (
    !standby_ctl_n.drv |=> !is_normal)
    else $error("normal mode entered with standby control undriven");
  chk_undriven_en: assert property (
    (standby_ctl_n.drv && standby_ctl_n.val && !mode_en_pin.drv &&
      state_reg != ftm_pkg::ST_SLEEP) |=> (state_reg == ftm_pkg::ST_PWR_STBY))
    else $error("undriven mode input not read as low");
endmodule

// [tb/ftm_ctrl_model.sv]
// protocol controller model that drives the transceiver's transmit and mode pins
`timescale 1ns/1ps
module ftm_ctrl_model #(
  parameter int unsigned BIT_CYC = 320
) (
  input  wire logic         clk,
  input  wire logic [1:0]   mode_req,
  input  wire logic         tx_req,
  input  wire logic [2:0]   float_req,
  output ftm_pkg::ftm_pin_t txd_pin,
  output ftm_pkg::ftm_pin_t standby_ctl_n,
  output ftm_pkg::ftm_pin_t mode_en_pin
);
  int unsigned bit_cnt;
  logic        tx_level;
  logic [1:0]  m_s;
  logic        t_s;
  logic [2:0]  f_s;

  initial begin
    bit_cnt = 0;
    tx_level = 1'b1;
    txd_pin = '{val: 1'b1, drv: 1'b1};
    standby_ctl_n = '{val: 1'b0, drv: 1'b1};
    mode_en_pin = '{val: 1'b0, drv: 1'b1};
  end

  // requests sampled on the edge, pins moved just after it; a floating pin toggles so
  // a design that ignores the drive bit sees garbage rather than a lucky value
  always @(posedge clk) begin
    m_s = mode_req;
    t_s = tx_req;
    f_s = float_req;
    #1;
    // bit edges no closer than one bit time keeps the rate at 125 kbaud
    if (bit_cnt != 0) begin
      bit_cnt = bit_cnt - 1;
    end else if (t_s != tx_level) begin
      tx_level = t_s;
      bit_cnt = BIT_CYC - 1;
    end
    // dominant is the low transmit level
    txd_pin.drv = !f_s[0];
    txd_pin.val = f_s[0] ? !txd_pin.val : tx_level;
    // mode pins select power-on standby with stb high, enable low
    standby_ctl_n.drv = !f_s[1];
    standby_ctl_n.val = f_s[1] ? !standby_ctl_n.val : m_s[1];
    mode_en_pin.drv = !f_s[2];
    mode_en_pin.val = f_s[2] ? !mode_en_pin.val : m_s[0];
  end
endmodule

// [tb/fault_tolerant_bus_failure_manager_bench.sv]
// self-checking bench of the bus failure manager against a controller model
`timescale 1ns/1ps
module fault_tolerant_bus_failure_manager_bench;
  localparam int unsigned TO_CYC = 3000;
  logic                  clk, rst, tx_req, local_wake_in, canh_dom_in, canl_dom_in;
  logic                  diff_dom_in, thermal_sd_in, vbat_por_in, rxd_out, fault_flag_out_n;
  logic                  regulator_inhibit_out, single_wire_out, tx_timeout_out;
  logic [1:0]            mode_req;
  logic [2:0]            float_req, dv;
  logic [7:0]            fail_raw_in;
  ftm_pkg::ftm_pin_t     txd_pin, standby_ctl_n, mode_en_pin;
  ftm_pkg::ftm_bus_ctl_t bus_ctl_out;
  int                    n_errors, checks, i, j, w;
  int                    q[$];
  logic                  hoff, loff, rx;

  ftm_ctrl_model u_ctrl (.clk(clk), .mode_req(mode_req), .tx_req(tx_req),
    .float_req(float_req), .txd_pin(txd_pin), .standby_ctl_n(standby_ctl_n),
    .mode_en_pin(mode_en_pin));

  ftm_bus_fail_mgr #(.TXD_TO_CYC(TO_CYC)) u_dut (.clk(clk), .rst(rst), .txd_pin(txd_pin),
    .standby_ctl_n(standby_ctl_n), .mode_en_pin(mode_en_pin), .local_wake_in(local_wake_in),
    .canh_dom_in(canh_dom_in), .canl_dom_in(canl_dom_in), .diff_dom_in(diff_dom_in),
    .fail_raw_in(fail_raw_in), .thermal_sd_in(thermal_sd_in), .vbat_por_in(vbat_por_in),
    .rxd_out(rxd_out), .fault_flag_out_n(fault_flag_out_n),
    .regulator_inhibit_out(regulator_inhibit_out), .bus_ctl_out(bus_ctl_out),
    .single_wire_out(single_wire_out), .tx_timeout_out(tx_timeout_out));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // inputs always move one ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_mode(input logic [1:0] m);
    mode_req = m;
    cyc(3);
  endtask

  // the model only moves the pin on a bit boundary, so wait for it under a bound
  task automatic set_tx(input logic v);
    int k;
    tx_req = v;
    for (k = 0; k < 400 && txd_pin.val !== v; k++) cyc(1);
    cyc(2);
  endtask

  // hang guard sized well above the ~34k cycles the tests need
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    rst = 1'b1; mode_req = 2'b00; tx_req = 1'b1; float_req = 3'b000;
    local_wake_in = 1'b0; canh_dom_in = 1'b0; canl_dom_in = 1'b0; diff_dom_in = 1'b0;
    fail_raw_in = 8'h00; thermal_sd_in = 1'b0; vbat_por_in = 1'b0;
    void'($urandom(84608));
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(2);
    // reset values, then the power-on flag only in power-on standby
    check("bus_ctl", bus_ctl_out, 4'h3);
    check("inhibit", regulator_inhibit_out, 1'b1);
    check("flag", fault_flag_out_n, 1'b1);
    set_mode(2'b10);
    check("flag", fault_flag_out_n, 1'b0);
    set_mode(2'b11);
    check("flag", fault_flag_out_n, 1'b1);
    set_mode(2'b10);
    check("flag", fault_flag_out_n, 1'b1);
    vbat_por_in = 1'b1;
    cyc(1);
    vbat_por_in = 1'b0;
    cyc(3);
    check("flag", fault_flag_out_n, 1'b0);
    $display("test power_on done");

    // transmit path, dominant timeout and thermal shutdown
    set_mode(2'b11);
    set_tx(1'b0);
    check("drivers", bus_ctl_out[3:2], 2'h3);
    cyc(TO_CYC - 20);
    check("timeout", tx_timeout_out, 1'b0);
    cyc(30);
    check("timeout", tx_timeout_out, 1'b1);
    check("drivers", bus_ctl_out[3:2], 2'h0);
    set_tx(1'b1);
    check("timeout", tx_timeout_out, 1'b0);
    set_tx(1'b0);
    thermal_sd_in = 1'b1;
    cyc(3);
    check("flag", fault_flag_out_n, 1'b0);
    check("drivers", bus_ctl_out[3:2], 2'h0);
    thermal_sd_in = 1'b0;
    cyc(3);
    check("flag", fault_flag_out_n, 1'b1);
    set_tx(1'b1);
    $display("test transmit done");

    // every failure type in random order: debounce, wire disabling, receive path
    for (i = 0; i < 8; i++) q.push_back(i);
    while (q.size() > 0) begin
      j = $urandom % q.size();
      i = q[j];
      q.delete(j);
      hoff = ftm_pkg::DRV_H_OFF[i];
      loff = ftm_pkg::DRV_L_OFF[i];
      fail_raw_in = 8'h01 << i;
      cyc(1180);
      check("single_wire", single_wire_out, 1'b0);
      check("flag", fault_flag_out_n, 1'b1);
      cyc(30);
      check("single_wire", single_wire_out, ftm_pkg::SW_MASK[i]);
      check("flag", fault_flag_out_n, 1'b0);
      check("bus_ctl", bus_ctl_out,
            {2'b00, !ftm_pkg::TERM_H_OFF[i], !ftm_pkg::TERM_L_OFF[i]});
      dv = 3'($urandom);
      {canh_dom_in, canl_dom_in, diff_dom_in} = dv;
      cyc(2);
      rx = hoff ? dv[1] : (loff ? dv[2] : dv[0]);
      check("rxd", rxd_out, !rx);
      {canh_dom_in, canl_dom_in, diff_dom_in} = 3'b000;
      set_tx(1'b0);
      check("drivers", bus_ctl_out[3:2], {!hoff, !loff});
      set_tx(1'b1);
      fail_raw_in = 8'h00;
      cyc(1180);
      check("flag", fault_flag_out_n, 1'b0);
      cyc(30);
      check("flag", fault_flag_out_n, 1'b1);
      check("single_wire", single_wire_out, 1'b0);
      check("bus_ctl", bus_ctl_out, 4'h3);
    end
    $display("test failures done");

    // local wake on both edges, then bus wake from either wire alone
    set_mode(2'b00);
    for (w = 0; w < 4; w++) begin
      if (w < 2) begin
        local_wake_in = !local_wake_in;
        cyc(3);
      end else begin
        {canh_dom_in, canl_dom_in} = (w == 2) ? 2'b10 : 2'b01;
        cyc(1590);
        check("rxd", rxd_out, 1'b1);
        cyc(20);
      end
      check("rxd", rxd_out, 1'b0);
      check("flag", fault_flag_out_n, 1'b0);
      {canh_dom_in, canl_dom_in} = 2'b00;
      set_mode(2'b11);
      check("flag", fault_flag_out_n, 1'b1);
      set_mode(2'b00);
    end
    $display("test wake done");

    // undriven standby control reads low, so enable alone means go-to-sleep
    float_req = 3'b010;
    set_mode(2'b11);
    cyc(1987);
    check("inhibit", regulator_inhibit_out, 1'b1);
    cyc(30);
    check("inhibit", regulator_inhibit_out, 1'b0);
    local_wake_in = !local_wake_in;
    cyc(3);
    check("inhibit", regulator_inhibit_out, 1'b1);
    float_req = 3'b000;
    set_mode(2'b11);
    set_mode(2'b01);
    cyc(500);
    local_wake_in = !local_wake_in;
    cyc(1600);
    check("inhibit", regulator_inhibit_out, 1'b1);
    set_mode(2'b11);
    // undriven enable leaves power-on standby: no transmit
    float_req = 3'b100;
    set_mode(2'b10);
    set_tx(1'b0);
    for (w = 0; w < 4; w++) begin
      cyc(1);
      check("drivers", bus_ctl_out[3:2], 2'h0);
    end
    set_tx(1'b1);
    float_req = 3'b001;
    set_mode(2'b11);
    for (w = 0; w < 4; w++) begin
      cyc(1);
      check("drivers", bus_ctl_out[3:2], 2'h0);
    end
    float_req = 3'b000;
    $display("test pin_defaults done");
    complete_run();
  end
endmodule
